// ===== verilog/udio_pkg.sv
package udio_pkg;

  // channel counts reported to the host
  localparam int unsigned INPUT_CHANNEL_COUNT  = 16;
  localparam int unsigned OUTPUT_CHANNEL_COUNT = 16;
  localparam int unsigned CHAN_IDX_W           = 4;

  // system clock
  localparam int unsigned CLK_HZ = 50_000_000;

  // update rates in updates per second
  localparam int unsigned IN_UPDATE_HZ  = 125;
  localparam int unsigned OUT_UPDATE_HZ = 125;

  // shortest input event that must be caught, in microseconds
  localparam int unsigned MIN_EVENT_US = 3000;

  // update periods in cycles (longest time, rounds down)
  localparam int unsigned IN_PERIOD_CYC  = CLK_HZ / IN_UPDATE_HZ;
  localparam int unsigned OUT_PERIOD_CYC = CLK_HZ / OUT_UPDATE_HZ;

  // input sampling interval: a third of the minimum event time, rounded down,
  // so any level held for the minimum time is seen on at least two samples
  localparam int unsigned SAMPLE_CYC = (CLK_HZ / 1_000_000) * MIN_EVENT_US / 3;

  // reset levels: outputs off, inputs inactive
  localparam logic [15:0] OUT_RESET_LEVEL = 16'h0000;
  localparam logic [15:0] IN_RESET_LEVEL  = 16'h0000;

  // one change notice to the host
  typedef struct packed {
    logic [CHAN_IDX_W-1:0] index;
    logic                  level;
  } udio_notice_s;

  // one periodic report to the host
  typedef struct packed {
    logic [15:0] input_channel_level;
    logic [15:0] output_channel_level;
  } udio_report_s;

endpackage : udio_pkg

// ===== verilog/udio_change_scan.sv
`timescale 1ns/1ps
// walks a changed-bit mask, emitting one notice per changed channel
module udio_change_scan
  import udio_pkg::*;
#(
  parameter int unsigned W = 16
)
(
  input  wire logic           clk,
  input  wire logic           rst_n,
  input  wire logic           ce,
  input  wire logic           load,        // pulse: take a new snapshot
  input  wire logic [W-1:0]   old_level,   // last reported levels
  input  wire logic [W-1:0]   new_level,   // freshly updated levels
  output logic                notice_valid,
  output udio_notice_s        notice,
  output logic                busy
);

  logic [W-1:0]          pend_q,  pend_d;   // channels still to notify
  logic [W-1:0]          lvl_q,   lvl_d;    // levels matching the snapshot
  logic                  nv_q,    nv_d;
  udio_notice_s          nt_q,    nt_d;

  // pick lowest pending channel; the host sees ascending order
  function automatic logic [CHAN_IDX_W-1:0] first_set(input logic [W-1:0] m);
    logic [CHAN_IDX_W-1:0] r;
    r = '0;
    for (int i = W - 1; i >= 0; i--)
    begin
      if (m[i])
        r = CHAN_IDX_W'(i);
    end
    return r;
  endfunction : first_set

  // next-state: load a mask, else retire one channel per cycle
  always_comb
  begin
    pend_d = pend_q;
    lvl_d  = lvl_q;
    nv_d   = 1'b0;
    nt_d   = nt_q;
    if (load)
    begin
      // a new snapshot replaces any leftover scan; periods are far longer
      pend_d = old_level ^ new_level;
      lvl_d  = new_level;
    end
    else if (|pend_q)
    begin
      nv_d        = 1'b1;
      nt_d.index  = first_set(pend_q);
      nt_d.level  = lvl_q[first_set(pend_q)];
      pend_d[first_set(pend_q)] = 1'b0;
    end
  end

  // register stage
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pend_q <= '0;
      lvl_q  <= '0;
      nv_q   <= 1'b0;
      nt_q   <= '0;
    end
    else if (ce)
    begin
      pend_q <= pend_d;
      lvl_q  <= lvl_d;
      nv_q   <= nv_d;
      nt_q   <= nt_d;
    end
  end

  assign notice_valid = nv_q;
  assign notice       = nt_q;
  assign busy         = |pend_q;

  // a pending channel is retired on the very next enabled cycle
  scan_drain_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && busy && !load) |=> notice_valid) else $error("pending channel not notified");

endmodule : udio_change_scan

// ===== verilog/udio_core.sv
`timescale 1ns/1ps
// Summary of operation
// - report sixteen input channels as fixed count
// - report sixteen output channels as fixed count
// - input reads true when externally activated
// - true request turns output on; default off
// - echo actual output state, not request
// - notify host on each input change
// - notify host on each output change
// - update inputs 125 times per second, sampling them every 1 ms
// - catch input changes lasting 3 ms
// - apply output requests 125 times per second
module udio_core
  import udio_pkg::*;
#(
  parameter int unsigned IN_PERIOD  = IN_PERIOD_CYC,
  parameter int unsigned OUT_PERIOD = OUT_PERIOD_CYC,
  parameter int unsigned SAMPLE     = SAMPLE_CYC
)
(
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         ce,
  input  wire logic [15:0]  input_pin,            // high while source active
  input  wire logic [15:0]  out_request,          // host requested levels
  input  wire logic         out_request_valid,    // pulse: new request word
  output logic [15:0]       out_switch_on,        // low-side switch drive
  output logic [7:0]        input_channel_count,
  output logic [7:0]        output_channel_count,
  output logic              input_change_valid,
  output udio_notice_s      input_change_notice,
  output logic              output_change_valid,
  output udio_notice_s      output_change_notice,
  output logic              report_valid,
  output udio_report_s      report
);

  // reset release through two flops
  logic rst_s1_q;
  logic rst_n;
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_s1_q <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_n    <= rst_s1_q;
    end
  end

  // timer state
  typedef enum logic [1:0] {
    UDIO_IDLE = 2'b01,
    UDIO_RUN  = 2'b10
  } udio_state_e;

  udio_state_e  st_q,     st_d;      // idle until first enabled cycle
  logic [31:0]  smp_q,    smp_d;     // input sample timer
  logic [31:0]  iper_q,   iper_d;    // input update timer
  logic [31:0]  oper_q,   oper_d;    // output update timer
  logic [15:0]  seen_q,   seen_d;    // sticky: level differing from report
  logic [15:0]  in_rep_q, in_rep_d;  // last reported input levels
  logic [15:0]  req_q,    req_d;     // pending host request
  logic [15:0]  out_q,    out_d;     // applied output levels
  logic         ilod_q,   ilod_d;    // input scan load pulse
  logic         olod_q,   olod_d;    // output scan load pulse
  logic [15:0]  iold_q,   iold_d;    // previous input levels for scan
  logic [15:0]  oold_q,   oold_d;    // previous output levels for scan
  logic         rv_q,     rv_d;
  udio_report_s rep_q,    rep_d;
  logic         in_tick, out_tick, smp_tick;

  function automatic logic tick(input logic [31:0] cnt, input int unsigned per);
    return cnt == 32'(per - 1);
  endfunction : tick

  assign smp_tick = tick(smp_q, SAMPLE);
  assign in_tick  = tick(iper_q, IN_PERIOD);
  assign out_tick = tick(oper_q, OUT_PERIOD);

  // next-state for timers, sampling, request latch and report
  always_comb
  begin
    st_d     = st_q;
    smp_d    = smp_q;
    iper_d   = iper_q;
    oper_d   = oper_q;
    seen_d   = seen_q;
    in_rep_d = in_rep_q;
    req_d    = req_q;
    out_d    = out_q;
    ilod_d   = 1'b0;
    olod_d   = 1'b0;
    iold_d   = iold_q;
    oold_d   = oold_q;
    rv_d     = 1'b0;
    rep_d    = rep_q;
    unique case (st_q)
      UDIO_IDLE:
        st_d = UDIO_RUN;
      UDIO_RUN:
      begin
        // free-running timers
        smp_d  = smp_tick ? '0 : smp_q + 32'd1;
        iper_d = in_tick  ? '0 : iper_q + 32'd1;
        oper_d = out_tick ? '0 : oper_q + 32'd1;
        // sample often; a changed level is held sticky so short events
        // between report ticks still get reported
        if (smp_tick)
          seen_d = seen_q | (input_pin ^ in_rep_q);
        // latest request wins until the next output update
        if (out_request_valid)
          req_d = out_request;
        if (in_tick)
        begin
          // a channel that changed and came back is toggled, so it is
          // reported once rather than lost
          in_rep_d = in_rep_q ^ (seen_d | (input_pin ^ in_rep_q));
          seen_d   = '0;
          iold_d   = in_rep_q;
          ilod_d   = 1'b1;
          rv_d     = 1'b1;
          rep_d.input_channel_level  = in_rep_d;
          // echo the level that stands after this edge; a request applied at
          // a coinciding output update is part of the actual state
          rep_d.output_channel_level = out_tick ? req_d : out_q;
        end
        if (out_tick)
        begin
          out_d  = req_d;
          oold_d = out_q;
          olod_d = 1'b1;
        end
      end
      default:
        st_d = UDIO_IDLE;
    endcase
  end

  // register stage
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q     <= UDIO_IDLE;
      smp_q    <= '0;
      iper_q   <= '0;
      oper_q   <= '0;
      seen_q   <= '0;
      in_rep_q <= IN_RESET_LEVEL;
      req_q    <= OUT_RESET_LEVEL;
      out_q    <= OUT_RESET_LEVEL;
      ilod_q   <= 1'b0;
      olod_q   <= 1'b0;
      iold_q   <= '0;
      oold_q   <= '0;
      rv_q     <= 1'b0;
      rep_q    <= '0;
    end
    else if (ce)
    begin
      st_q     <= st_d;
      smp_q    <= smp_d;
      iper_q   <= iper_d;
      oper_q   <= oper_d;
      seen_q   <= seen_d;
      in_rep_q <= in_rep_d;
      req_q    <= req_d;
      out_q    <= out_d;
      ilod_q   <= ilod_d;
      olod_q   <= olod_d;
      iold_q   <= iold_d;
      oold_q   <= oold_d;
      rv_q     <= rv_d;
      rep_q    <= rep_d;
    end
  end

  // notice scanners: one channel per cycle, lowest index first
  udio_change_scan #(.W(16)) u_in_scan (
    .clk          (clk),
    .rst_n        (rst_n),
    .ce           (ce),
    .load         (ilod_q),
    .old_level    (iold_q),
    .new_level    (in_rep_q),
    .notice_valid (input_change_valid),
    .notice       (input_change_notice),
    .busy         ()
  );

  udio_change_scan #(.W(16)) u_out_scan (
    .clk          (clk),
    .rst_n        (rst_n),
    .ce           (ce),
    .load         (olod_q),
    .old_level    (oold_q),
    .new_level    (out_q),
    .notice_valid (output_change_valid),
    .notice       (output_change_notice),
    .busy         ()
  );

  // outputs straight from flops; counts are fixed constants
  assign out_switch_on        = out_q;
  assign input_channel_count  = 8'(INPUT_CHANNEL_COUNT);
  assign output_channel_count = 8'(OUTPUT_CHANNEL_COUNT);
  assign report_valid         = rv_q;
  assign report               = rep_q;

  // request is applied only at an output update
  out_apply_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && $changed(out_q)) |-> $past(out_tick)) else $error("output moved off tick");

  report_echo_a: assert property (@(posedge clk) disable iff (!rst_n)
    report_valid |-> report.output_channel_level == out_q)
    else $error("report does not echo outputs");

  sequence in_update_s;
    ce && in_tick && st_q == UDIO_RUN;
  endsequence
  report_period_a: assert property (@(posedge clk) disable iff (!rst_n)
    in_update_s |=> report_valid) else $error("report missing after update");

  count_fixed_a: assert property (@(posedge clk) disable iff (!rst_n)
    input_channel_count == 8'h10 && output_channel_count == 8'h10)
    else $error("channel count wrong");

  // an input notice carries the level now reported for that channel
  in_notice_a: assert property (@(posedge clk) disable iff (!rst_n)
    input_change_valid |-> input_change_notice.level == in_rep_q[input_change_notice.index])
    else $error("input notice level stale");

  // an output notice carries the level now applied to that channel
  out_notice_a: assert property (@(posedge clk) disable iff (!rst_n)
    output_change_valid |-> output_change_notice.level == out_q[output_change_notice.index])
    else $error("output notice level stale");

endmodule : udio_core

// ===== testbench/udio_host_model.sv
`timescale 1ns/1ps
// host side: knows the channels only through the notices and the periodic reports
module udio_host_model
  import udio_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          input_change_valid,
  input  wire udio_notice_s  input_change_notice,
  input  wire logic          output_change_valid,
  input  wire udio_notice_s  output_change_notice,
  input  wire logic          report_valid,
  input  wire udio_report_s  report,
  output logic [15:0]        out_request,
  output logic               out_request_valid
);
  logic [15:0]  in_view  = 16'h0000;  // inputs as notified
  logic [15:0]  out_view = 16'h0000;  // outputs as echoed, never as asked
  int           in_cnt   = 0;         // input notices seen
  int           out_cnt  = 0;         // output notices seen
  int           cyc      = 0;         // free cycle count
  int           rep_cyc  = 0;         // cycle of newest report
  int           gap      = 0;         // cycles between last two reports
  udio_report_s last_rep = '0;        // newest report

  initial
  begin
    out_request       = 16'h0000;
    out_request_valid = 1'b0;
  end

  // one-cycle strobe; word inverted after release so stale data is not reused
  task automatic send(input logic [15:0] w);
    @(negedge clk);
    out_request       = w;
    out_request_valid = 1'b1;
    @(negedge clk);
    out_request_valid = 1'b0;
    out_request       = ~w;
  endtask : send

  // views follow notices only, so a lost notice shows up as a stale bit
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (input_change_valid === 1'b1)
    begin
      in_view[input_change_notice.index] <= input_change_notice.level;
      in_cnt <= in_cnt + 1;
    end
    if (output_change_valid === 1'b1)
    begin
      out_view[output_change_notice.index] <= output_change_notice.level;
      out_cnt <= out_cnt + 1;
    end
    if (report_valid === 1'b1)
    begin
      last_rep <= report;
      gap      <= cyc - rep_cyc;
      rep_cyc  <= cyc;
    end
  end
endmodule : udio_host_model

// ===== testbench/udio_core_bench.sv
`timescale 1ns/1ps
// top bench: drives pins, asks via the host model, checks what it learns
module udio_core_bench
  import udio_pkg::*;
;
  localparam int PER = 64;  // shortened update period
  typedef struct packed {
    logic [15:0] pin;    // input levels applied
    logic [15:0] req;    // output levels asked for
    logic [7:0]  n_in;   // input notices expected
    logic [7:0]  n_out;  // output notices expected
  } udio_row_s;
  udio_row_s    rows [4] = '{'{16'h0001, 16'h8000, 8'h01, 8'h01},
                             '{16'hffff, 16'hffff, 8'h0f, 8'h0f},
                             '{16'ha5a5, 16'h5a5a, 8'h08, 8'h08},
                             '{16'h0000, 16'h0000, 8'h08, 8'h08}};
  logic         clk  = 1'b0;
  logic         nrst = 1'b0;
  logic         ce   = 1'b1;
  logic [15:0]  pin  = 16'h0000;
  logic [15:0]  req;
  logic         req_v;
  logic [15:0]  sw;
  logic [7:0]   cnt_i;
  logic [7:0]   cnt_o;
  logic         iv;
  logic         ov;
  logic         rv;
  udio_notice_s in_n;
  udio_notice_s out_n;
  udio_report_s rep;
  int           bad_count = 0;
  int           checks    = 0;
  int           n;
  int           ci;
  int           co;

  always #10 clk = ~clk;

  udio_core #(.IN_PERIOD(PER), .OUT_PERIOD(PER), .SAMPLE(8)) i_dut (
    .clk(clk), .nrst(nrst), .ce(ce), .input_pin(pin), .out_request(req),
    .out_request_valid(req_v), .out_switch_on(sw), .input_channel_count(cnt_i),
    .output_channel_count(cnt_o), .input_change_valid(iv),
    .input_change_notice(in_n), .output_change_valid(ov),
    .output_change_notice(out_n), .report_valid(rv), .report(rep));

  udio_host_model i_host (
    .clk(clk), .input_change_valid(iv), .input_change_notice(in_n),
    .output_change_valid(ov), .output_change_notice(out_n),
    .report_valid(rv), .report(rep), .out_request(req), .out_request_valid(req_v));

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk32

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    chk32({16'h0000, got}, {16'h0000, exp});
  endtask : chk16

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    chk32({24'h000000, got}, {24'h000000, exp});
  endtask : chk8

  // bounded wait for the applied outputs to move
  task automatic wait_chg(output int k);
    logic [15:0] prev;
    prev = sw;
    k = 0;
    while (sw === prev && k < 200)
    begin
      @(negedge clk);
      k++;
    end
  endtask : wait_chg

  task automatic complete_run;
    if (bad_count == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : complete_run

  // watchdog: the sequence needs about 1350 cycles
  initial
  begin
    repeat (5000) @(posedge clk);
    bad_count++;
    complete_run;
  end

  initial
  begin
    repeat (8) @(negedge clk);
    chk16(sw, OUT_RESET_LEVEL);
    chk8(cnt_i, 8'(INPUT_CHANNEL_COUNT));
    chk8(cnt_o, 8'(OUTPUT_CHANNEL_COUNT));
    repeat (8) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    foreach (rows[i])
    begin
      ci  = i_host.in_cnt;
      co  = i_host.out_cnt;
      pin = rows[i].pin;
      i_host.send(rows[i].req);
      repeat (160) @(negedge clk);
      chk16(sw, rows[i].req);
      chk16(i_host.out_view, rows[i].req);
      chk16(i_host.in_view, rows[i].pin);
      chk32(i_host.last_rep, {rows[i].pin, rows[i].req});
      chk8(8'(i_host.in_cnt - ci), rows[i].n_in);
      chk8(8'(i_host.out_cnt - co), rows[i].n_out);
    end
    chk8(8'(i_host.gap), 8'(PER));
    // a pulse of three sample intervals: one notice out, one back
    ci  = i_host.in_cnt;
    pin = 16'h0008;
    repeat (24) @(negedge clk);
    pin = 16'h0000;
    repeat (200) @(negedge clk);
    chk8(8'(i_host.in_cnt - ci), 8'h02);
    // sync on a tick, then two requests before the next: the last wins
    i_host.send(16'h00ff);
    wait_chg(n);
    i_host.send(16'h1234);
    i_host.send(16'h4321);
    wait_chg(n);
    chk16(sw, 16'h4321);
    chk8(8'(n + 4), 8'(PER));
    // clock enable low: nothing taken, nothing applied
    ce = 1'b0;
    i_host.send(16'hffff);
    repeat (200) @(negedge clk);
    chk16(sw, 16'h4321);
    ce = 1'b1;
    repeat (160) @(negedge clk);
    chk16(sw, 16'h4321);
    // reset in mid-run drops every output back to off
    nrst = 1'b0;
    repeat (2) @(negedge clk);
    chk16(sw, OUT_RESET_LEVEL);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    complete_run;
  end
endmodule : udio_core_bench
